// *** gli_pkg.sv ***
// gli_pkg: constants, modes, states and carriers of the gpio/led block.
// assumes a 25 MHz core clock and status levels from the mac/phy domain.
package gli_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam longint CLK_HZ       = 64'd25_000_000;
    localparam longint MS_PER_S     = 64'd1000;
    localparam longint LED_PULSE_MS = 64'd80;
    // least time, so round up
    localparam int     LED_PULSE_CYC =
        int'((LED_PULSE_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);

    // ************************************************************
    // pins
    // ************************************************************
    localparam int NUM_PINS = 3;
    localparam int PIN_SPEED  = 0;
    localparam int PIN_LINK   = 1;
    localparam int PIN_DUPLEX = 2;

    // ************************************************************
    // modes and states
    // ************************************************************
    typedef enum logic [1:0] {
        GLI_MODE_INPUT = 2'h0,
        GLI_MODE_PUSH  = 2'h1,
        GLI_MODE_OPEN  = 2'h2
    } gli_mode_t;

    typedef enum logic [1:0] {
        GLI_ACT_NO_LINK = 2'h0,
        GLI_ACT_SOLID   = 2'h1,
        GLI_ACT_BLINK   = 2'h2,
        GLI_ACT_HOLD    = 2'h3
    } gli_act_state_t;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic      led_en;
        gli_mode_t mode;
        logic      out_val;
    } gli_pin_cfg_t;

    localparam gli_pin_cfg_t PIN_CFG_RST = '{
        led_en:  1'b0,
        mode:    GLI_MODE_INPUT,
        out_val: 1'b0
    };

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic autoneg_busy;
        logic full_duplex;
        logic activity;
    } gli_link_status_t;

    typedef struct packed {
        logic o;
        logic oe;
    } gli_pin_drive_t;

endpackage

// *** gli_gpio_led.sv ***
// gli_gpio_led: three general pins, each a gpio or a status led driver.
// assumes status and configuration come from logic on clk_sys; pin
// inputs are asynchronous and are synchronised here.
//
// Contract
// [RL1] Each pin is set by configuration as push-pull output, open-drain output or input.
// [RL2] Each pin may instead carry its led function when its led enable is set.
// [RL3] A pin in led function is open-drain, pulling low only and never driving high.
// [RL4] The speed led is low at 100Mb and high in auto-negotiation, without cable and at 10Mb.
// [RL5] The link-and-activity led is held low while a valid link is present.
// [RL6] Activity with link up sends the link-and-activity led high for 80 ms.
// [RL7] After each high pulse the led is low for at least 80 ms, then pulses again only on activity.
// [RL8] The duplex led is low in full duplex and released high otherwise.
// [RL9] Without a valid link the link-and-activity led is released high and never blinks.
// [RL10] After reset all pins are inputs with led functions off until configured.
`timescale 1ns/1ps
`default_nettype none

module gli_gpio_led #(
    parameter int PULSE_CYCLES = gli_pkg::LED_PULSE_CYC
) (
    // clock and reset
    input  wire  logic                                    clk_sys,
    input  wire  logic                                    rst,
    // configuration, one entry per pin
    input  wire  gli_pkg::gli_pin_cfg_t [gli_pkg::NUM_PINS-1:0] pin_cfg,
    // status from phy and mac
    input  wire  gli_pkg::gli_link_status_t               link_status,
    // pins
    input  wire  logic [gli_pkg::NUM_PINS-1:0]            pin_i,
    output logic [gli_pkg::NUM_PINS-1:0]                  pin_o,
    output logic [gli_pkg::NUM_PINS-1:0]                  pin_oe,
    // pin levels seen by software
    output logic [gli_pkg::NUM_PINS-1:0]                  pin_in_val,
    // led levels, low means lit
    output logic                                          speed_indicator_n,
    output logic                                          link_activity_indicator_n,
    output logic                                          duplex_indicator_n
);

    localparam int NP    = gli_pkg::NUM_PINS;
    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ************************************************************
    // configuration capture
    // ************************************************************
    gli_pkg::gli_pin_cfg_t [NP-1:0] cfg_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NP; i++) begin
                cfg_q[i] <= gli_pkg::PIN_CFG_RST; // see [RL10]
            end
        end else begin
            cfg_q <= pin_cfg;
        end
    end

    // ************************************************************
    // pin input synchroniser
    // ************************************************************
    logic [NP-1:0] sync1_q;
    logic [NP-1:0] sync2_q;
    logic [NP-1:0] sync3_q;
    logic [NP-1:0] pin_in_val_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // change counts once second and third stages agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_in_val_q <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_in_val_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign pin_in_val = pin_in_val_q;

    // ************************************************************
    // speed and duplex leds
    // ************************************************************
    logic speed_n_q;
    logic duplex_n_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            speed_n_q  <= 1'b1;
            duplex_n_q <= 1'b1;
        end else begin
            speed_n_q  <= ~(link_status.link_up & link_status.speed_100 &
                            ~link_status.autoneg_busy); // see [RL4]
            duplex_n_q <= ~(link_status.link_up &
                            link_status.full_duplex); // see [RL8]
        end
    end

    // ************************************************************
    // link and activity led
    // ************************************************************
    gli_pkg::gli_act_state_t act_state_q;
    gli_pkg::gli_act_state_t act_state_d;
    logic [CNT_W-1:0]        act_cnt_q;
    logic                    act_seen_q;
    logic                    cnt_done;
    logic                    link_n_q;

    assign cnt_done = (act_cnt_q == CNT_LAST);

    always_comb begin
        act_state_d = act_state_q;
        unique case (act_state_q)
            gli_pkg::GLI_ACT_NO_LINK: begin
                if (link_status.link_up) begin
                    act_state_d = gli_pkg::GLI_ACT_SOLID;
                end
            end
            gli_pkg::GLI_ACT_SOLID: begin
                if (link_status.activity) begin
                    act_state_d = gli_pkg::GLI_ACT_BLINK; // see [RL6]
                end
            end
            gli_pkg::GLI_ACT_BLINK: begin
                if (cnt_done) begin
                    act_state_d = gli_pkg::GLI_ACT_HOLD; // see [RL7]
                end
            end
            gli_pkg::GLI_ACT_HOLD: begin
                if (cnt_done) begin
                    act_state_d = (act_seen_q | link_status.activity) ?
                                  gli_pkg::GLI_ACT_BLINK :
                                  gli_pkg::GLI_ACT_SOLID; // see [RL7]
                end
            end
        endcase
        if (!link_status.link_up) begin
            act_state_d = gli_pkg::GLI_ACT_NO_LINK; // see [RL9]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            act_state_q <= gli_pkg::GLI_ACT_NO_LINK;
        end else begin
            act_state_q <= act_state_d;
        end
    end

    // period counter, restarts on every state change
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            act_cnt_q <= CNT_ZERO;
        end else if (act_state_d != act_state_q) begin
            act_cnt_q <= CNT_ZERO;
        end else if (!cnt_done) begin
            act_cnt_q <= act_cnt_q + CNT_ONE; // see [RL6] [RL7]
        end
    end

    // activity latched from pulse start to end of hold
    logic act_start;

    assign act_start = (act_state_d == gli_pkg::GLI_ACT_BLINK) &&
                       (act_state_q != gli_pkg::GLI_ACT_BLINK);

    // activity that starts a pulse is used up by it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            act_seen_q <= 1'b0;
        end else if (act_start ||
                     act_state_d == gli_pkg::GLI_ACT_NO_LINK) begin
            act_seen_q <= 1'b0; // see [RL9]
        end else if (link_status.activity) begin
            act_seen_q <= 1'b1; // see [RL7]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link_n_q <= 1'b1;
        end else begin
            link_n_q <= (act_state_d == gli_pkg::GLI_ACT_NO_LINK) ||
                        (act_state_d == gli_pkg::GLI_ACT_BLINK); // see [RL5]
        end
    end

    assign speed_indicator_n         = speed_n_q;
    assign link_activity_indicator_n = link_n_q;
    assign duplex_indicator_n        = duplex_n_q;

    // ************************************************************
    // pin drivers
    // ************************************************************
    function automatic gli_pkg::gli_pin_drive_t pin_drive(
        input gli_pkg::gli_pin_cfg_t cfg,
        input logic                  led_n
    );
        gli_pkg::gli_pin_drive_t drv;
        drv.o  = 1'b0;
        drv.oe = 1'b0;
        if (cfg.led_en) begin
            drv.oe = ~led_n; // see [RL2] [RL3]
        end else begin
            case (cfg.mode)
                gli_pkg::GLI_MODE_PUSH: begin
                    drv.o  = cfg.out_val; // see [RL1]
                    drv.oe = 1'b1;
                end
                gli_pkg::GLI_MODE_OPEN: begin
                    drv.oe = ~cfg.out_val; // see [RL1]
                end
                default: begin
                    drv.oe = 1'b0; // see [RL1]
                end
            endcase
        end
        return drv;
    endfunction

    logic [NP-1:0] led_n_vec;
    logic [NP-1:0] pin_o_q;
    logic [NP-1:0] pin_oe_q;

    always_comb begin
        led_n_vec             = '1;
        led_n_vec[gli_pkg::PIN_SPEED]  = speed_n_q;
        led_n_vec[gli_pkg::PIN_LINK]   = link_n_q;
        led_n_vec[gli_pkg::PIN_DUPLEX] = duplex_n_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_o_q  <= '0;
            pin_oe_q <= '0; // see [RL10]
        end else begin
            for (int i = 0; i < NP; i++) begin
                {pin_o_q[i], pin_oe_q[i]} <= pin_drive(cfg_q[i],
                                                       led_n_vec[i]);
            end
        end
    end

    assign pin_o  = pin_o_q;
    assign pin_oe = pin_oe_q;

endmodule

`default_nettype wire

// *** gli_gpio_led_asserts.sv ***
// gli_gpio_led_asserts: port timing checks of the gpio/led block.
// assumes a bind into gli_gpio_led, pulse length from its parameter.
`timescale 1ns/1ps
`default_nettype none
module gli_gpio_led_asserts #(
    parameter int PULSE_CYCLES = gli_pkg::LED_PULSE_CYC
) (
    // clock and reset
    input wire logic                                       clk_sys,
    input wire logic                                       rst,
    // block inputs
    input wire gli_pkg::gli_pin_cfg_t [gli_pkg::NUM_PINS-1:0] pin_cfg,
    input wire gli_pkg::gli_link_status_t                  link_status,
    input wire logic [gli_pkg::NUM_PINS-1:0]               pin_i,
    // block outputs
    input wire logic [gli_pkg::NUM_PINS-1:0]               pin_o,
    input wire logic [gli_pkg::NUM_PINS-1:0]               pin_oe,
    input wire logic [gli_pkg::NUM_PINS-1:0]               pin_in_val,
    input wire logic                                       speed_indicator_n,
    input wire logic                                 link_activity_indicator_n,
    input wire logic                                       duplex_indicator_n
);
    // ************************************************************
    // pulse and gap counters
    // ************************************************************
    wire logic   lnk = link_status.link_up;
    wire logic   led = link_activity_indicator_n;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic        done_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hi_q <= 32'h0;
            lo_q <= 32'h0;
            done_q <= 1'b0;
        end else begin
            hi_q <= (lnk && led) ? hi_q + 32'h1 : 32'h0;
            lo_q <= (lnk && !led) ? lo_q + 32'h1 : 32'h0;
            done_q <= lnk && (done_q || (hi_q == PULSE_CYCLES && !led));
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rst_in; $fell(rst) |-> pin_oe == 3'h0 ##1 pin_oe == 3'h0;
    endproperty
    a_rst_in: assert property (p_rst_in)
        else $error("pin driven after reset");
    property p_speed; speed_indicator_n == !$past(lnk
        && link_status.speed_100 && !link_status.autoneg_busy); endproperty
    a_speed: assert property (p_speed)
        else $error("speed led level");
    property p_duplex; duplex_indicator_n ==
        !$past(lnk && link_status.full_duplex); endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex led level");
    property p_nolink; !$past(lnk) |-> led; endproperty
    a_nolink: assert property (p_nolink)
        else $error("led lit without link");
    property p_rise; $rose(lnk) |=> !led; endproperty
    a_rise: assert property (p_rise)
        else $error("led not lit on link");
    // led leaves reset high, so a fall right after reset is no pulse
    property p_pulse; $fell(led) && $past(lnk) && $past(lnk, 2)
        && !$past(rst, 2) |-> hi_q == PULSE_CYCLES; endproperty
    a_pulse: assert property (p_pulse)
        else $error("pulse length");
    property p_gap; $rose(led) && $past(lnk) && done_q
        |-> lo_q >= PULSE_CYCLES; endproperty
    a_gap: assert property (p_gap)
        else $error("gap too short");
    property p_push; $past(pin_cfg[0].mode, 2) == gli_pkg::GLI_MODE_PUSH
        && !$past(pin_cfg[0].led_en, 2)
        |-> pin_oe[0] && pin_o[0] == $past(pin_cfg[0].out_val, 2); endproperty
    a_push: assert property (p_push)
        else $error("push-pull drive");
    property p_open; $past(pin_cfg[1].mode, 2) == gli_pkg::GLI_MODE_OPEN
        && !$past(pin_cfg[1].led_en, 2) |-> !pin_o[1]
        && pin_oe[1] == !$past(pin_cfg[1].out_val, 2); endproperty
    a_open: assert property (p_open)
        else $error("open-drain drive");
    property p_led_od; $past(pin_cfg[2].led_en, 2) |-> !pin_o[2]
        && pin_oe[2] == !$past(duplex_indicator_n); endproperty
    a_led_od: assert property (p_led_od)
        else $error("led pin drive");
endmodule
bind gli_gpio_led gli_gpio_led_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .pin_cfg(pin_cfg),
    .link_status(link_status), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_in_val(pin_in_val),
    .speed_indicator_n(speed_indicator_n),
    .link_activity_indicator_n(link_activity_indicator_n),
    .duplex_indicator_n(duplex_indicator_n));
`default_nettype wire

// *** gli_board.sv ***
// gli_board: pull-ups and an external low drive on the three pins.
// assumes pin_o/pin_oe from the block; its level feeds pin_i.
`timescale 1ns/1ps
`default_nettype none
module gli_board (
    // from block
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe,
    // board side
    input  wire logic [2:0] ext_low,
    // wire level
    output logic      [2:0] pin_lvl
);
    // pulled up unless someone pulls low
    assign pin_lvl = ~(pin_oe & ~pin_o) & ~ext_low;
endmodule
`default_nettype wire

// *** test_gli_gpio_led.sv ***
// test_gli_gpio_led: self-checking bench of the gpio/led block.
// assumes gli_board on the pins and a short pulse parameter.
`timescale 1ns/1ps
`default_nettype none
module test_gli_gpio_led;
    localparam int P = 8;
    logic                        clk_sys, rst, spd_n, lnk_n, dup_n;
    gli_pkg::gli_pin_cfg_t [2:0] cfg;
    gli_pkg::gli_link_status_t   st;
    logic [2:0]                  ext_low, lvl, pin_o, pin_oe, in_val;
    int                          errors, compares, cyc, n;
    gli_gpio_led #(.PULSE_CYCLES(P)) uut (.clk_sys(clk_sys), .rst(rst),
        .pin_cfg(cfg), .link_status(st), .pin_i(lvl), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_in_val(in_val), .speed_indicator_n(spd_n),
        .link_activity_indicator_n(lnk_n), .duplex_indicator_n(dup_n));
    gli_board board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low),
        .pin_lvl(lvl));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic run(input logic v);
        n = 0;
        while (lnk_n === v && n < 100) begin
            tick(1);
            n++;
        end
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_gpio;
        logic [1:0] oe_x;
        logic [2:0] in_x;
        for (int m = 0; m < 8; m++) begin
            ext_low = (m / 2 == 1) ? 3'h0 : 3'h5;
            for (int i = 0; i < 3; i++) cfg[i] = '{1'b0,
                gli_pkg::gli_mode_t'(m / 2), m[0]};
            tick(2);
            oe_x = (m / 2 == 1) ? 2'h3 : (m / 2 == 2) ? {!m[0], 1'b0} : 2'h0;
            chk(pin_oe, {3{oe_x[1]}}, "pin enable");
            chk(pin_o, {3{m / 2 == 1 && m[0]}}, "pin out");
            tick(5);
            in_x = (m / 2 == 1) ? {3{m[0]}} : (m / 2 == 2) ? {1'b0, m[0], 1'b0}
                 : 3'h2;
            chk(in_val, in_x, "pin in");
        end
        ext_low = 3'h0;
    endtask
    task automatic t_status;
        for (int i = 0; i < 3; i++) cfg[i] = '{1'b1,
            gli_pkg::GLI_MODE_PUSH, 1'b1};
        for (int i = 0; i < 16; i++) begin
            st = gli_pkg::gli_link_status_t'({i[3:0], 1'b0});
            tick(3);
            chk(spd_n, !(i[3] && i[2] && !i[1]), "speed led");
            chk(dup_n, !(i[3] && i[0]), "duplex led");
            chk(lnk_n, !i[3], "link led");
            chk(pin_o, 3'h0, "led pin high");
            chk(pin_oe, {~dup_n, ~lnk_n, ~spd_n},
                "led pin enable");
        end
    endtask
    task automatic t_link;
        st = gli_pkg::gli_link_status_t'(5'h10);
        tick(5);
        chk(lnk_n, 1'b0, "link led");
        st.activity = 1'b1;
        tick(1);
        st.activity = 1'b0;
        run(1'b1);
        chk(n, P, "pulse length");
        st.activity = 1'b1;
        run(1'b0);
        chk(n >= P && n < 100, 1'b1, "gap");
        run(1'b1);
        chk(n, P, "second pulse");
        st.activity = 1'b0;
        tick(5 * P);
        run(1'b0);
        chk(n, 100, "blink without activity");
        // short activity in mid pulse must bring one more pulse
        st.activity = 1'b1;
        tick(1);
        st.activity = 1'b0;
        tick(3);
        st.activity = 1'b1;
        tick(1);
        st.activity = 1'b0;
        run(1'b1);
        run(1'b0);
        chk(n, P, "gap before latched pulse");
        run(1'b1);
        chk(n, P, "latched pulse");
        st.link_up = 1'b0;
        st.activity = 1'b1;
        tick(2);
        run(1'b1);
        chk(n, 100, "led without link");
    endtask
    task automatic t_reset;
        st = gli_pkg::gli_link_status_t'(5'h10);
        tick(3);
        rst = 1'b1;
        tick(2);
        chk(pin_oe, 3'h0, "pins driven in reset");
        chk(lnk_n, 1'b1, "led lit in reset");
        rst = 1'b0;
        tick(1);
        chk(pin_oe, 3'h0, "pins driven after reset");
        tick(1);
        chk(pin_oe, 3'h2, "led pin after reset");
    endtask
    task automatic results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        cfg = '0;
        st = '0;
        ext_low = 3'h0;
        tick(6);
        rst = 1'b0;
        tick(5);
        chk(pin_oe, 3'h0, "pins driven");
        chk({spd_n, lnk_n, dup_n}, 3'h7, "leds lit");
        chk(in_val, 3'h7, "pins not inputs");
        t_gpio();
        t_status();
        t_link();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
